// ### verilog/dsrw_top.sv
// dsrw_top: data-space decode, program-memory window and return stack.
// assumes the core issues one data access at a time, synchronous to clk,
// and the program memory returns a byte in the same cycle as pm_rd_q.
`timescale 1ns/1ps

module dsrw_top
  import dsrw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // core data-space access
  input  wire logic [7:0]  da_addr,
  input  wire logic        da_rd,
  input  wire logic        da_wr,
  input  wire logic [7:0]  da_wdata,
  output logic [7:0]       da_rdata_q,
  output logic             da_rvalid_q,
  output logic             da_busy_q,
  // region decode of the last access
  output logic             sel_bank_q,
  output logic             sel_window_q,
  output logic             sel_other_q,
  // program memory read port
  output logic [11:0]      pm_addr_q,
  output logic             pm_rd_q,
  input  wire logic [7:0]  pm_rdata,
  // return stack
  input  wire logic        stk_push,
  input  wire logic        stk_pop,
  input  wire logic [11:0] stk_push_pc,
  output logic [11:0]      stk_pop_pc_q,
  output logic             stk_pop_valid_q,
  output logic [2:0]       stk_count_q,
  output logic             stk_overflow_q,
  output logic             stk_underflow_q
);

  function automatic dsrw_region_type region_of(input logic [7:0] a);
    if (a <= DSRW_BANK_HI) begin
      return DSRW_REG_BANK;
    end else if (a >= DSRW_WIN_LO && a <= DSRW_WIN_HI) begin
      return DSRW_REG_WINDOW;
    end else begin
      return DSRW_REG_OTHER;
    end
  endfunction : region_of

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    return (p == DSRW_PTR_LAST) ? DSRW_PTR_RST : 3'(p + 3'h1);
  endfunction : ptr_inc

  function automatic logic [2:0] ptr_dec(input logic [2:0] p);
    return (p == DSRW_PTR_RST) ? DSRW_PTR_LAST : 3'(p - 3'h1);
  endfunction : ptr_dec

  // base bits on top, the low six address bits below
  function automatic logic [11:0] window_addr(input logic [5:0] base,
                                              input logic [7:0] a);
    return {base, a[DSRW_OFS_W-1:0]};
  endfunction : window_addr

  // base register
  logic [5:0] window_base_bits;
  logic       base_wr;

  // a read at this offset is not claimed, so the base never leaks out
  always_comb begin
    base_wr = da_wr && (da_addr == DSRW_OFS_WIN_BASE);
  end

  dsrw_win_base u_base (
    .clk              (clk),
    .wr_en            (base_wr),
    .wr_data          (da_wdata),
    .window_base_bits (window_base_bits)
  );

  // region decode
  dsrw_region_type region;
  logic            sel_bank_d;
  logic            sel_window_d;
  logic            sel_other_d;

  always_comb begin
    region       = region_of(da_addr);
    sel_bank_d   = sel_bank_q;
    sel_window_d = sel_window_q;
    sel_other_d  = sel_other_q;
    if (da_rd || da_wr) begin
      sel_bank_d   = (region == DSRW_REG_BANK);
      sel_window_d = (region == DSRW_REG_WINDOW);
      sel_other_d  = (region == DSRW_REG_OTHER);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_bank_q   <= 1'b0;
      sel_window_q <= 1'b0;
      sel_other_q  <= 1'b0;
    end else begin
      sel_bank_q   <= sel_bank_d;
      sel_window_q <= sel_window_d;
      sel_other_q  <= sel_other_d;
    end
  end

  // window read sequencer: request side
  dsrw_rd_state_type rd_state_q;
  dsrw_rd_state_type rd_state_d;
  logic [11:0]       pm_addr_d;
  logic              pm_rd_d;
  logic              da_busy_d;
  logic              win_req;

  // writes into the window are dropped: the region is read-only
  // a read during the fetch cycle is dropped too; the core spaces them
  always_comb begin
    win_req    = da_rd && (region == DSRW_REG_WINDOW);
    rd_state_d = rd_state_q;
    pm_addr_d  = pm_addr_q;
    pm_rd_d    = 1'b0;
    da_busy_d  = 1'b0;
    case (rd_state_q)
      DSRW_RD_IDLE: begin
        if (win_req) begin
          pm_addr_d  = window_addr(window_base_bits, da_addr);
          pm_rd_d    = 1'b1;
          da_busy_d  = 1'b1;
          rd_state_d = DSRW_RD_FETCH;
        end
      end
      DSRW_RD_FETCH: begin
        rd_state_d = DSRW_RD_IDLE;
      end
      default: begin
        rd_state_d = DSRW_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_state_q <= DSRW_RD_IDLE;
      pm_addr_q  <= DSRW_PC_RST;
      pm_rd_q    <= 1'b0;
      da_busy_q  <= 1'b0;
    end else begin
      rd_state_q <= rd_state_d;
      pm_addr_q  <= pm_addr_d;
      pm_rd_q    <= pm_rd_d;
      da_busy_q  <= da_busy_d;
    end
  end

  // window read sequencer: answer side
  logic [7:0] da_rdata_d;
  logic       da_rvalid_d;

  // the byte is taken while the fetch strobe stands
  always_comb begin
    da_rdata_d  = da_rdata_q;
    da_rvalid_d = 1'b0;
    if (rd_state_q == DSRW_RD_FETCH) begin
      da_rdata_d  = pm_rdata;
      da_rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      da_rdata_q  <= DSRW_BYTE_RST;
      da_rvalid_q <= 1'b0;
    end else begin
      da_rdata_q  <= da_rdata_d;
      da_rvalid_q <= da_rvalid_d;
    end
  end

  // return stack control
  dsrw_stack_if stk ();

  dsrw_stack_mem u_stack (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (stk.mem)
  );

  logic [2:0] sp_q;
  logic [2:0] sp_d;
  logic [2:0] count_d;
  logic       do_push;
  logic       do_pop;

  // push and pop together is treated as no operation
  always_comb begin
    do_push   = stk_push && !stk_pop;
    do_pop    = stk_pop && !stk_push;
    stk.we    = do_push;
    stk.waddr = sp_q;
    stk.wdata = stk_push_pc;
    stk.raddr = ptr_dec(sp_q);
  end

  // full stack: newest push overwrites oldest entry, count stays
  always_comb begin
    sp_d    = sp_q;
    count_d = stk_count_q;
    if (do_push) begin
      sp_d = ptr_inc(sp_q);
      if (stk_count_q != DSRW_CNT_FULL) begin
        count_d = 3'(stk_count_q + 3'h1);
      end
    end else if (do_pop) begin
      sp_d = ptr_dec(sp_q);
      if (stk_count_q != DSRW_PTR_RST) begin
        count_d = 3'(stk_count_q - 3'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_q        <= DSRW_PTR_RST;
      stk_count_q <= DSRW_PTR_RST;
    end else begin
      sp_q        <= sp_d;
      stk_count_q <= count_d;
    end
  end

  // sticky flags: only reset clears them, software has no clear
  logic overflow_d;
  logic underflow_d;

  always_comb begin
    overflow_d  = stk_overflow_q;
    underflow_d = stk_underflow_q;
    if (do_push && stk_count_q == DSRW_CNT_FULL) begin
      overflow_d = 1'b1;
    end
    if (do_pop && stk_count_q == DSRW_PTR_RST) begin
      underflow_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stk_overflow_q  <= 1'b0;
      stk_underflow_q <= 1'b0;
    end else begin
      stk_overflow_q  <= overflow_d;
      stk_underflow_q <= underflow_d;
    end
  end

  // pop answer: slot read data are registered, so two cycles after the pop
  logic        pop_pend_q;
  logic        pop_pend_d;
  logic [11:0] pop_pc_d;
  logic        pop_valid_d;

  always_comb begin
    pop_pend_d  = do_pop;
    pop_pc_d    = stk_pop_pc_q;
    pop_valid_d = 1'b0;
    if (pop_pend_q) begin
      pop_pc_d    = stk.rdata;
      pop_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pop_pend_q      <= 1'b0;
      stk_pop_pc_q    <= DSRW_PC_RST;
      stk_pop_valid_q <= 1'b0;
    end else begin
      pop_pend_q      <= pop_pend_d;
      stk_pop_pc_q    <= pop_pc_d;
      stk_pop_valid_q <= pop_valid_d;
    end
  end

endmodule : dsrw_top

// ### verilog/dsrw_pkg.sv
// dsrw_pkg: constants and types shared by the data-space window block.
// assumes an 8-bit data space and a 12-bit program space.
package dsrw_pkg;

  // data-space layout
  localparam logic [7:0] DSRW_BANK_LO      = 8'h00;
  localparam logic [7:0] DSRW_BANK_HI      = 8'h3F;
  localparam logic [7:0] DSRW_WIN_LO       = 8'h40;
  localparam logic [7:0] DSRW_WIN_HI       = 8'h7F;

  // register offsets in data space
  localparam logic [7:0] DSRW_OFS_IND_FIRST  = 8'h80;
  localparam logic [7:0] DSRW_OFS_IND_SECOND = 8'h81;
  localparam logic [7:0] DSRW_OFS_SHD_FIRST  = 8'h82;
  localparam logic [7:0] DSRW_OFS_SHD_SECOND = 8'h83;
  localparam logic [7:0] DSRW_OFS_WIN_BASE   = 8'hC9;
  localparam logic [7:0] DSRW_OFS_ACC        = 8'hFF;

  // window base field and address split
  localparam int DSRW_BASE_LSB   = 0;
  localparam int DSRW_BASE_W     = 6;
  localparam int DSRW_OFS_W      = 6;
  localparam int DSRW_PC_W       = 12;

  // return stack geometry
  localparam int              DSRW_STK_DEPTH = 6;
  localparam int              DSRW_PTR_W     = 3;
  localparam logic [2:0]      DSRW_PTR_LAST  = 3'h5;
  localparam logic [2:0]      DSRW_CNT_FULL  = 3'h6;
  localparam logic [2:0]      DSRW_PTR_RST   = 3'h0;
  localparam logic [11:0]     DSRW_PC_RST    = 12'h000;
  localparam logic [7:0]      DSRW_BYTE_RST  = 8'h00;

  // window read sequencer, one-hot
  typedef enum logic [1:0] {
    DSRW_RD_IDLE  = 2'b01,
    DSRW_RD_FETCH = 2'b10
  } dsrw_rd_state_type;

  // data-space region, one-hot
  typedef enum logic [2:0] {
    DSRW_REG_BANK   = 3'b001,
    DSRW_REG_WINDOW = 3'b010,
    DSRW_REG_OTHER  = 3'b100
  } dsrw_region_type;

endpackage : dsrw_pkg

// ### verilog/dsrw_stack_if.sv
// dsrw_stack_if: port bundle between the top and the return-stack memory.
// assumes a single clock; write and read are both synchronous.
`timescale 1ns/1ps
interface dsrw_stack_if;
  logic        we;
  logic [2:0]  waddr;
  logic [11:0] wdata;
  logic [2:0]  raddr;
  logic [11:0] rdata;

  modport ctrl (
    output we,
    output waddr,
    output wdata,
    output raddr,
    input  rdata
  );

  modport mem (
    input  we,
    input  waddr,
    input  wdata,
    input  raddr,
    output rdata
  );
endinterface : dsrw_stack_if

// ### verilog/dsrw_stack_mem.sv
// dsrw_stack_mem: six 12-bit return-address slots, registered read.
// assumes addresses below six; the top never issues others.
`timescale 1ns/1ps
module dsrw_stack_mem
  import dsrw_pkg::*;
(
  // clock and reset
  input wire logic    clk,
  input wire logic    rst_n,
  // memory port
  dsrw_stack_if.mem   port
);

  logic [11:0] slot_q [DSRW_STK_DEPTH];
  logic [11:0] rdata_q;
  logic [11:0] rdata_d;

  always_comb begin
    rdata_d = slot_q[port.raddr];
  end

  // slots carry no reset, like the real stack
  always_ff @(posedge clk) begin
    if (port.we) begin
      slot_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= DSRW_PC_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign port.rdata = rdata_q;

endmodule : dsrw_stack_mem

// ### verilog/dsrw_win_base.sv
// dsrw_win_base: write-only window base register, six bits kept.
// assumes the core writes it by data-space address; never read back.
`timescale 1ns/1ps
module dsrw_win_base
  import dsrw_pkg::*;
(
  // clock
  input wire logic        clk,
  // write port
  input wire logic        wr_en,
  input wire logic [7:0]  wr_data,
  // window base to the address former
  output logic [5:0]      window_base_bits
);

  logic [5:0] base_q;
  logic [5:0] base_d;

  // bits 7 and 6 dropped on purpose
  always_comb begin
    base_d = base_q;
    if (wr_en) begin
      base_d = wr_data[DSRW_BASE_LSB +: DSRW_BASE_W];
    end
  end

  // no reset: value survives reset undefined, software must load it
  always_ff @(posedge clk) begin
    base_q <= base_d;
  end

  assign window_base_bits = base_q;

endmodule : dsrw_win_base

// ### test/dsrw_top_checker.sv
// dsrw_top_checker: window, base and stack timing checks on dsrw_top.
// assumes one clock domain; bound onto every dsrw_top instance.
`timescale 1ns/1ps
module dsrw_top_checker
  import dsrw_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // data access
  input wire logic [7:0]  da_addr,
  input wire logic        da_rd,
  input wire logic        da_wr,
  input wire logic [7:0]  da_wdata,
  input wire logic [7:0]  da_rdata_q,
  input wire logic        da_rvalid_q,
  input wire logic        da_busy_q,
  // program memory
  input wire logic [11:0] pm_addr_q,
  input wire logic        pm_rd_q,
  input wire logic [7:0]  pm_rdata,
  // stack
  input wire logic        stk_push,
  input wire logic        stk_pop,
  input wire logic        stk_pop_valid_q,
  input wire logic [2:0]  stk_count_q,
  input wire logic        stk_overflow_q,
  input wire logic        stk_underflow_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic win;
  assign win = da_addr inside {[DSRW_WIN_LO:DSRW_WIN_HI]};
  sequence win_rd_s; da_rd && win && !pm_rd_q; endsequence
  sequence base_wr_s; da_wr && da_addr == DSRW_OFS_WIN_BASE; endsequence
  sequence fetch_s;
    pm_rd_q && da_busy_q && pm_addr_q[5:0] == $past(da_addr[5:0])
    ##1 da_rvalid_q && da_rdata_q == $past(pm_rdata);
  endsequence
  win_fetch_a: assert property (win_rd_s |=> fetch_s)
    else $error("window read not answered in two cycles");
  b2b_refuse_a: assert property (pm_rd_q |=> !pm_rd_q && !da_busy_q)
    else $error("fetch pulse too long or back to back");
  base_map_a: assert property (base_wr_s ##2 win_rd_s
    |=> pm_addr_q[11:6] == $past(da_wdata[5:0], 3))
    else $error("window base not applied");
  win_only_a: assert property (pm_rd_q |-> $past(da_rd) && $past(win))
    else $error("fetch outside window reads");
  no_readback_a: assert property (da_rvalid_q |-> $past(pm_rd_q))
    else $error("read answer without fetch");
  push_cnt_a: assert property (stk_push && !stk_pop
    && stk_count_q < DSRW_CNT_FULL |=> stk_count_q == $past(stk_count_q) + 3'h1)
    else $error("push did not count");
  full_wrap_a: assert property (stk_push && !stk_pop
    && stk_count_q == DSRW_CNT_FULL |=> stk_count_q == 3'h6 && stk_overflow_q)
    else $error("push on full stack wrong");
  pop_ans_a: assert property (stk_pop && !stk_push |=> ##1 stk_pop_valid_q)
    else $error("pop not answered");
  under_flag_a: assert property (stk_pop && !stk_push
    && stk_count_q == 3'h0 |=> stk_underflow_q)
    else $error("underflow not flagged");
endmodule : dsrw_top_checker

bind dsrw_top dsrw_top_checker u_chk (.*);

// ### test/dsrw_pm_model.sv
// dsrw_pm_model: program memory behind the window, fixed byte pattern.
// assumes pm_rdata is only sampled while pm_rd_q is high.
`timescale 1ns/1ps
module dsrw_pm_model (
  // request
  input wire logic [11:0] pm_addr_q,
  input wire logic        pm_rd_q,
  // answer
  output logic [7:0]      pm_rdata
);
  logic [7:0] byte_v;
  assign byte_v = pm_addr_q[7:0] ^ {2{pm_addr_q[11:8]}};
  // inverted off-request so a late sample shows up
  assign pm_rdata = pm_rd_q ? byte_v : ~byte_v;
endmodule : dsrw_pm_model

// ### test/tb.sv
// tb: window, base register and return stack traffic on dsrw_top.
// assumes dsrw_pm_model on the program memory port.
`timescale 1ns/1ps
module tb
  import dsrw_pkg::*;
;
  logic        clk, rst_n, da_rd, da_wr, stk_push, stk_pop;
  logic        da_rvalid_q, da_busy_q, pm_rd_q, stk_pop_valid_q;
  logic        sel_bank_q, sel_window_q, sel_other_q;
  logic        stk_overflow_q, stk_underflow_q;
  logic [7:0]  da_addr, da_wdata, da_rdata_q, pm_rdata;
  logic [11:0] pm_addr_q, stk_push_pc, stk_pop_pc_q;
  logic [2:0]  stk_count_q;
  logic [5:0]  base;
  logic [12:0] e;
  logic [12:0] sq[$];
  logic [7:0]  wq[$];
  logic [11:0] pcs[7];
  int          n_errors = 0, compares = 0, cyc = 0;

  dsrw_top dut (.*);
  dsrw_pm_model u_pm (.*);

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic final_report();
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {2{a[11:8]}};
  endfunction : pat

  // n edges of strobe: n of 2 makes a back-to-back pair
  task automatic acc(input logic [7:0] a, input logic rd, wr,
                     input logic [7:0] wd, input int n);
    @(posedge clk);
    #1;
    da_addr = a;
    da_rd = rd;
    da_wr = wr;
    da_wdata = wd;
    repeat (n) @(posedge clk);
    #1;
    da_rd = 1'b0;
    da_wr = 1'b0;
    chk({sel_bank_q, sel_window_q, sel_other_q},
        a < 8'h40 ? 3'h4 : a < 8'h80 ? 3'h2 : 3'h1);
  endtask : acc

  task automatic rd(input logic [5:0] o);
    wq.push_back(pat({base, o}));
    acc({2'b01, o}, 1'b1, 1'b0, 8'h00, 1);
  endtask : rd

  task automatic wb(input logic [7:0] v);
    base = v[5:0];
    acc(DSRW_OFS_WIN_BASE, 1'b0, 1'b1, v, 1);
  endtask : wb

  task automatic stk(input logic pu, po, input logic [11:0] pc);
    @(posedge clk);
    #1;
    stk_push = pu;
    stk_pop = po;
    stk_push_pc = pc;
    @(posedge clk);
    #1;
    stk_push = 1'b0;
    stk_pop = 1'b0;
  endtask : stk

  always @(negedge clk) begin
    if (da_rvalid_q === 1'b1) begin
      chk(wq.size() > 0, 1'b1);
      if (wq.size() > 0) chk(da_rdata_q, wq.pop_front());
    end
    if (stk_pop_valid_q === 1'b1) begin
      chk(sq.size() > 0, 1'b1);
      if (sq.size() > 0) begin
        e = sq.pop_front();
        if (!e[12]) chk(stk_pop_pc_q, e[11:0]);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    {rst_n, da_rd, da_wr, stk_push, stk_pop} = 5'h00;
    {da_addr, da_wdata, stk_push_pc} = 28'h0000000;
    void'($urandom(32'hE320));
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({stk_count_q, stk_overflow_q, stk_underflow_q}, 5'h00);
    // base is undefined after reset, so it is loaded first
    wb(8'hFF);
    rd(6'h00);
    rd(6'h3F);
    for (int i = 0; i < 12; i++) begin
      wb(8'($urandom()));
      repeat (3) rd(6'($urandom()));
    end
    wq.push_back(pat({base, 6'h11}));
    acc(8'h51, 1'b1, 1'b0, 8'h00, 2);
    acc(8'h47, 1'b0, 1'b1, 8'h5A, 1);
    acc(DSRW_OFS_WIN_BASE, 1'b1, 1'b0, 8'h00, 1);
    acc(8'h12, 1'b1, 1'b0, 8'h00, 1);
    rd(6'h2A);
    for (int i = 0; i < 7; i++) begin
      pcs[i] = 12'($urandom());
      stk(1'b1, 1'b0, pcs[i]);
      chk(stk_count_q, 13'(i < 6 ? i + 1 : 6));
    end
    chk(stk_overflow_q, 1'b1);
    stk(1'b1, 1'b1, 12'hABC);
    chk(stk_count_q, 3'h6);
    for (int i = 6; i > 0; i--) begin
      sq.push_back({1'b0, pcs[i]});
      stk(1'b0, 1'b1, 12'h000);
    end
    chk(stk_count_q, 3'h0);
    sq.push_back(13'h1000);
    stk(1'b0, 1'b1, 12'h000);
    chk(stk_underflow_q, 1'b1);
    repeat (4) @(posedge clk);
    chk(wq.size() + sq.size(), 13'h0000);
    final_report();
  end
endmodule : tb
